// ===== rtl/smsp_map.vh
// constants for the serial master/slave port: register map, fields, rates
// assumes inclusion by its bare name from every design file of the block
`ifndef SMSP_MAP_VH
`define SMSP_MAP_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define SMSP_ADDR_W 8
`define SMSP_OFS_CONTROL 8'h00
`define SMSP_OFS_STATUS 8'h04
`define SMSP_OFS_DATA 8'h08
`define SMSP_OFS_PIN_CFG 8'h0c

// ****************************************************************
// control fields
// ****************************************************************
`define SMSP_CTL_IRQ_EN 7
`define SMSP_CTL_PORT_EN 6
`define SMSP_CTL_LSB_FIRST 5
`define SMSP_CTL_MASTER 4
`define SMSP_CTL_CLOCK_IDLE_POLARITY 3
`define SMSP_CTL_CLOCK_SAMPLE_PHASE 2
`define SMSP_CTL_RATE_HI 1
`define SMSP_CTL_RATE_LO 0
`define SMSP_CTL_RESET 8'h00

// ****************************************************************
// status fields and pin configuration fields
// ****************************************************************
`define SMSP_STS_DONE 7
`define SMSP_STS_WRITE_COLLISION_FLAG 6
`define SMSP_STS_DSPEED 0
`define SMSP_PIN_SS_DIR_OUT 0
`define SMSP_PIN_SS_LEVEL 1

// ****************************************************************
// half sck periods in pclk cycles, normal and double speed
// ****************************************************************
`define SMSP_HALF_N0 7'h02
`define SMSP_HALF_N1 7'h08
`define SMSP_HALF_N2 7'h20
`define SMSP_HALF_N3 7'h40
`define SMSP_HALF_D0 7'h01
`define SMSP_HALF_D1 7'h04
`define SMSP_HALF_D2 7'h10
`define SMSP_HALF_D3 7'h20

// ****************************************************************
// edge counts of one byte
// ****************************************************************
`define SMSP_LAST_EDGE 5'h0f
`define SMSP_LAST_SMP_CPHA0 5'h0e
`define SMSP_LAST_SMP_CPHA1 5'h0f

`endif

// ===== rtl/smsp_rate_div.v
// master sck rate divider: one pulse per half sck period
// assumes run is held high for the whole master transfer
`include "smsp_map.vh"

module smsp_rate_div (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire run,
  input wire double_speed,
  input wire [1:0] rate_sel,
  // half period pulse
  output wire half_tick
);

  reg [6:0] cnt_reg;
  reg [6:0] half_len;

  // ****************************************************************
  // half period length from the rate code
  // ****************************************************************
  always @* begin
    case ({double_speed, rate_sel})
      3'h0: half_len = `SMSP_HALF_N0;
      3'h1: half_len = `SMSP_HALF_N1;
      3'h2: half_len = `SMSP_HALF_N2;
      3'h3: half_len = `SMSP_HALF_N3;
      3'h4: half_len = `SMSP_HALF_D0;
      3'h5: half_len = `SMSP_HALF_D1;
      3'h6: half_len = `SMSP_HALF_D2;
      default: half_len = `SMSP_HALF_D3;
    endcase
  end

  assign half_tick = run && (cnt_reg == half_len - 7'h01);

  // ****************************************************************
  // counter, restarts whenever idle
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 7'h00;
    end else if (!run || half_tick) begin
      cnt_reg <= 7'h00;
    end else begin
      cnt_reg <= cnt_reg + 7'h01;
    end
  end

endmodule

// ===== rtl/smsp_port.v
// serial master/slave byte port with an apb register slave
// assumes pins arrive synchronous to pclk; oe_n low means the port drives
//
// Our own choices: register access over APB and the address map.
`include "smsp_map.vh"

module smsp_port (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`SMSP_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // processor side
  input wire global_irq_enable,
  input wire irq_vector_ack,
  output wire xfer_irq,
  // sck pin
  input wire sck_in,
  output wire sck_out,
  output wire sck_oe_n,
  // mosi pin
  input wire mosi_in,
  output wire mosi_out,
  output wire mosi_oe_n,
  // miso pin
  input wire miso_in,
  output wire miso_out,
  output wire miso_oe_n,
  // slave select pin
  input wire ss_in,
  output wire ss_out,
  output wire ss_oe_n
);

  // ****************************************************************
  // state
  // ****************************************************************
  reg [7:0] ctrl_reg;
  reg dspeed_reg;
  reg done_flag_reg;
  reg write_collision_flag_reg;
  reg [1:0] pin_cfg_reg;
  reg [7:0] rx_buf_reg;
  reg [7:0] shift_reg;
  reg [7:0] tx_hold_reg;
  reg out_bit_reg;
  reg sck_level_reg;
  reg sck_prev_reg;
  reg busy_reg;
  reg [4:0] edge_cnt_reg;
  reg arm_done_reg;
  reg arm_write_collision_flag_reg;
  reg [31:0] prdata_reg;
  reg pready_reg;
  reg pslverr_reg;
  reg irq_reg;
  reg sck_oe_n_reg;
  reg mosi_oe_n_reg;
  reg miso_oe_n_reg;
  reg ss_oe_n_reg;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // address decode: 0 control, 1 status, 2 data, 3 pins, 4 unmapped
  function [2:0] sel_of;
    input [`SMSP_ADDR_W-1:0] a;
    begin
      case (a)
        `SMSP_OFS_CONTROL: sel_of = 3'h0;
        `SMSP_OFS_STATUS: sel_of = 3'h1;
        `SMSP_OFS_DATA: sel_of = 3'h2;
        `SMSP_OFS_PIN_CFG: sel_of = 3'h3;
        default: sel_of = 3'h4;
      endcase
    end
  endfunction

  // bit that goes out next
  function top_bit;
    input [7:0] sr;
    input lsb;
    begin
      top_bit = lsb ? sr[0] : sr[7];
    end
  endfunction

  // shift in one received bit
  function [7:0] shift_in;
    input [7:0] sr;
    input lsb;
    input b;
    begin
      shift_in = lsb ? {b, sr[7:1]} : {sr[6:0], b};
    end
  endfunction

  // ****************************************************************
  // control decode
  // ****************************************************************
  wire en = ctrl_reg[`SMSP_CTL_PORT_EN];
  wire master = ctrl_reg[`SMSP_CTL_MASTER];
  wire lsb = ctrl_reg[`SMSP_CTL_LSB_FIRST];
  wire clock_idle_polarity = ctrl_reg[`SMSP_CTL_CLOCK_IDLE_POLARITY];
  wire clock_sample_phase = ctrl_reg[`SMSP_CTL_CLOCK_SAMPLE_PHASE];
  wire ss_dir_out = pin_cfg_reg[`SMSP_PIN_SS_DIR_OUT];

  // apb access phase strobes
  wire acc = psel && penable && pready_reg;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire [2:0] sel = sel_of(paddr);
  wire data_acc = acc && (sel == 3'h2);

  // master transfer clock
  wire half_tick;
  wire run = busy_reg && en && master;

  smsp_rate_div u_rate_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .double_speed(dspeed_reg),
    .rate_sel(ctrl_reg[1:0]),
    .half_tick(half_tick)
  );

  // ss low with ss as input while master: another master took the bus
  wire mode_fault = en && master && !ss_dir_out && !ss_in;
  // slave is selected only while ss is low
  wire slave_act = en && !master && !ss_in;

  // ****************************************************************
  // sck edge classification
  // ****************************************************************
  reg ev_lead;
  reg ev_trail;
  reg in_bit;
  always @* begin
    ev_lead = 1'b0;
    ev_trail = 1'b0;
    in_bit = 1'b0;
    if (run && !mode_fault) begin
      // own sck: leading when leaving the idle level
      ev_lead = half_tick && (sck_level_reg == clock_idle_polarity);
      ev_trail = half_tick && (sck_level_reg != clock_idle_polarity);
      in_bit = miso_in;
    end else if (slave_act) begin
      // external sck edges; rate bits play no part here
      ev_lead = (sck_in != sck_prev_reg) && (sck_prev_reg == clock_idle_polarity);
      ev_trail = (sck_in != sck_prev_reg) && (sck_prev_reg != clock_idle_polarity) && (edge_cnt_reg != 5'h00);
      in_bit = mosi_in;
    end
  end

  // sample and setup edges from phase
  wire ev_smp = clock_sample_phase ? ev_trail : ev_lead;
  wire ev_stp = clock_sample_phase ? ev_lead : ev_trail;
  wire [7:0] shifted = shift_in(shift_reg, lsb, in_bit);

  // end of byte: 16 master edges, or eighth slave sample
  wire last_smp = clock_sample_phase ? (edge_cnt_reg == `SMSP_LAST_SMP_CPHA1) : (edge_cnt_reg == `SMSP_LAST_SMP_CPHA0);
  wire m_done = run && !mode_fault && half_tick && (edge_cnt_reg == `SMSP_LAST_EDGE);
  wire s_done = slave_act && ev_smp && last_smp;
  wire xfer_end = m_done || s_done;

  // a transfer is in flight
  wire in_flight = (en && master && busy_reg) || (slave_act && (edge_cnt_reg != 5'h00));
  wire data_wr = wr && (sel == 3'h2);
  wire start_ok = data_wr && en && !in_flight;

  // ****************************************************************
  // register file and flags
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SMSP_CTL_RESET;
      dspeed_reg <= 1'b0;
      done_flag_reg <= 1'b0;
      write_collision_flag_reg <= 1'b0;
      pin_cfg_reg <= 2'h0;
      arm_done_reg <= 1'b0;
      arm_write_collision_flag_reg <= 1'b0;
    end else begin
      // control write; a mode fault wins and drops master role
      if (wr && sel == 3'h0) begin
        ctrl_reg <= pwdata[7:0];
      end
      if (mode_fault) begin
        ctrl_reg[`SMSP_CTL_MASTER] <= 1'b0;
      end
      if (wr && sel == 3'h1) begin
        dspeed_reg <= pwdata[`SMSP_STS_DSPEED];
      end
      if (wr && sel == 3'h3) begin
        pin_cfg_reg <= pwdata[1:0];
      end
      // status read arms the clear on the captured flag values
      if (rd && sel == 3'h1) begin
        arm_done_reg <= prdata_reg[`SMSP_STS_DONE] || prdata_reg[`SMSP_STS_WRITE_COLLISION_FLAG];
        arm_write_collision_flag_reg <= prdata_reg[`SMSP_STS_WRITE_COLLISION_FLAG];
      end else if (data_acc) begin
        arm_done_reg <= 1'b0;
        arm_write_collision_flag_reg <= 1'b0;
      end
      // done flag: set beats any clear
      if (xfer_end || mode_fault) begin
        done_flag_reg <= 1'b1;
      end else if (irq_vector_ack) begin
        done_flag_reg <= 1'b0;
      end else if (data_acc && arm_done_reg) begin
        done_flag_reg <= 1'b0;
      end
      // collision flag: set beats clear
      if (data_wr && in_flight) begin
        write_collision_flag_reg <= 1'b1;
      end else if (data_acc && arm_write_collision_flag_reg) begin
        write_collision_flag_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // shift engine
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= 8'h00;
      tx_hold_reg <= 8'h00;
      rx_buf_reg <= 8'h00;
      out_bit_reg <= 1'b0;
      sck_level_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
      busy_reg <= 1'b0;
      edge_cnt_reg <= 5'h00;
    end else begin
      sck_prev_reg <= sck_in;
      if (!en || mode_fault) begin
        // disabled or forced out of master: abandon the byte
        busy_reg <= 1'b0;
        edge_cnt_reg <= 5'h00;
        sck_level_reg <= clock_idle_polarity;
      end else if (start_ok) begin
        // new byte loads the shift register and starts
        shift_reg <= pwdata[7:0];
        tx_hold_reg <= pwdata[7:0];
        out_bit_reg <= top_bit(pwdata[7:0], lsb);
        busy_reg <= master;
        edge_cnt_reg <= 5'h00;
      end else if (!master && ss_in) begin
        // slave deselected: restart, put the byte back
        edge_cnt_reg <= 5'h00;
        if (edge_cnt_reg != 5'h00) begin
          shift_reg <= tx_hold_reg;
        end
        out_bit_reg <= top_bit((edge_cnt_reg != 5'h00) ? tx_hold_reg : shift_reg, lsb);
      end else begin
        if (run && half_tick) begin
          sck_level_reg <= ~sck_level_reg;
        end else if (!busy_reg) begin
          sck_level_reg <= clock_idle_polarity;
        end
        if (ev_smp) begin
          shift_reg <= shifted;
        end
        if (ev_stp) begin
          out_bit_reg <= top_bit(shift_reg, lsb);
        end
        if (xfer_end) begin
          edge_cnt_reg <= 5'h00;
          busy_reg <= 1'b0;
          rx_buf_reg <= ev_smp ? shifted : shift_reg;
        end else if (ev_lead || ev_trail) begin
          edge_cnt_reg <= edge_cnt_reg + 5'h01;
        end
      end
    end
  end

  // ****************************************************************
  // apb read data and handshake
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      // ready in the cycle after setup, so every transfer has one access cycle
      pready_reg <= psel && !penable && !pready_reg;
      pslverr_reg <= psel && !penable && !pready_reg && (sel == 3'h4);
      if (psel && !penable && !pwrite) begin
        case (sel)
          3'h0: prdata_reg <= {24'h000000, ctrl_reg};
          3'h1: prdata_reg <= {24'h000000, done_flag_reg, write_collision_flag_reg, 5'h00, dspeed_reg};
          3'h2: prdata_reg <= {24'h000000, rx_buf_reg};
          3'h3: prdata_reg <= {30'h00000000, pin_cfg_reg};
          default: prdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************************************
  // interrupt and pin enables
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
      sck_oe_n_reg <= 1'b1;
      mosi_oe_n_reg <= 1'b1;
      miso_oe_n_reg <= 1'b1;
      ss_oe_n_reg <= 1'b1;
    end else begin
      irq_reg <= ctrl_reg[`SMSP_CTL_IRQ_EN] && done_flag_reg && global_irq_enable;
      // master drives sck and mosi; lost master role lets them go
      sck_oe_n_reg <= !(en && master && !mode_fault);
      mosi_oe_n_reg <= !(en && master && !mode_fault);
      miso_oe_n_reg <= !slave_act;
      // ss as output is general purpose only
      ss_oe_n_reg <= !ss_dir_out;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign xfer_irq = irq_reg;
  assign sck_out = sck_level_reg;
  assign sck_oe_n = sck_oe_n_reg;
  assign mosi_out = out_bit_reg;
  assign mosi_oe_n = mosi_oe_n_reg;
  assign miso_out = out_bit_reg;
  assign miso_oe_n = miso_oe_n_reg;
  assign ss_out = pin_cfg_reg[`SMSP_PIN_SS_LEVEL];
  assign ss_oe_n = ss_oe_n_reg;

endmodule

// ===== verification/smsp_monitor.sv
// assertions on the serial port's apb answers, irq and pin enables
// assumes binding into smsp_port, pins sampled on pclk
`include "smsp_map.vh"

module smsp_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SMSP_ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // processor side
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  input wire logic xfer_irq,
  // pins
  input wire logic sck_oe_n,
  input wire logic mosi_oe_n,
  input wire logic miso_oe_n,
  input wire logic ss_in,
  input wire logic ss_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic mapped = paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ****
  // apb answers
  // ****
  sequence setup_s;
    psel && !penable;
  endsequence
  setup_ready_a: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  ready_once_a: assert property (pready |-> (psel && penable) ##1 !pready)
    else $error("ready outside one access cycle");
  bad_addr_a: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  good_addr_a: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  status_rsvd_a: assert property (pready && !pwrite && paddr == `SMSP_OFS_STATUS |-> prdata[5:1] == 5'h0)
    else $error("reserved status bits set");

  // ****
  // pins and interrupt
  // ****
  sequence fault_s;
    !sck_oe_n && ss_oe_n && !ss_in;
  endsequence
  fault_release_a: assert property (fault_s |-> ##[1:2] sck_oe_n)
    else $error("sck still driven after select fault");
  pin_pair_a: assert property (sck_oe_n == mosi_oe_n)
    else $error("sck and mosi drive differ");
  miso_sel_a: assert property (!miso_oe_n |-> !$past(ss_in))
    else $error("miso driven while unselected");
  irq_gate_a: assert property (xfer_irq |-> $past(global_irq_enable))
    else $error("irq without global enable");
  ack_clear_a: assert property (irq_vector_ack ##1 1'b1 |=> !xfer_irq)
    else $error("irq after vector ack");
endmodule

bind smsp_port smsp_monitor smsp_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack), .xfer_irq(xfer_irq),
  .sck_oe_n(sck_oe_n), .mosi_oe_n(mosi_oe_n), .miso_oe_n(miso_oe_n), .ss_in(ss_in), .ss_oe_n(ss_oe_n)
);

// ===== verification/smsp_peer.sv
// behavioural external slave answering the port in master role
// assumes sck and mosi are the resolved pin levels
module smsp_peer (
  // pins
  input wire logic sck,
  input wire logic mosi,
  output wire logic miso,
  // setup
  input wire logic sel,
  input wire logic clock_idle_polarity,
  input wire logic clock_sample_phase,
  input wire logic lsb,
  input wire logic [7:0] tx,
  output logic [7:0] rx
);
  timeunit 1ns;
  timeprecision 1ns;
  int k;
  int o;
  logic park = 1'b0;
  wire logic smp = ~(clock_idle_polarity ^ clock_sample_phase);
  wire logic b = tx[lsb ? o[2:0] : 3'h7 - o[2:0]];
  // restart bit counts at each selection
  always @(posedge sel) begin
    k = 0;
    o = 0;
  end
  // sample on one edge, set up on the other
  always @(sck) if (sel) begin
    if (sck == smp) begin
      rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
      k = k + 1;
    end else
      o = k;
  end
  // released line shows the inverse of its last bit
  always @(negedge sel) park = ~b;
  assign miso = sel ? b : park;
endmodule

// ===== verification/smsp_port_tb_top.sv
// self-checking bench for the serial port: apb driver, pin wires, peer
// assumes smsp_port with its bound monitor and smsp_peer
module smsp_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic gie = 1'b0, ack = 1'b0, tb_sck = 1'b0, tb_mosi = 1'b0, tb_ss = 1'b1;
  logic peer_sel = 1'b0, clock_idle_polarity = 1'b0, clock_sample_phase = 1'b0, lsb = 1'b0, ds;
  logic [1:0] r;
  logic [7:0] peer_tx = 8'h00, d, s, q;
  logic [32:0] e;
  logic [31:0] m;
  logic [32:0] exp_q[$];
  logic [31:0] msk_q[$];
  int seed = 32'h368c2ef5;
  int n_fail = 0, n_compared = 0, cyc = 0;
  int hn[4] = '{8'h02, 8'h08, 8'h20, 8'h40};
  wire logic [31:0] prdata;
  wire logic pready, pslverr, xfer_irq, peer_miso;
  wire logic sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, ss_out, ss_oe_n;
  wire logic [7:0] peer_rx;
  // resolved pin levels
  wire logic sck_w = sck_oe_n ? tb_sck : sck_out;
  wire logic mosi_w = mosi_oe_n ? tb_mosi : mosi_out;
  wire logic miso_w = miso_oe_n ? peer_miso : miso_out;
  wire logic ss_w = ss_oe_n ? tb_ss : ss_out;

  always #25 pclk = ~pclk;

  smsp_port smsp_port_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_irq_enable(gie), .irq_vector_ack(ack), .xfer_irq(xfer_irq),
    .sck_in(sck_w), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
    .miso_in(miso_w), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
    .ss_in(ss_w), .ss_out(ss_out), .ss_oe_n(ss_oe_n)
  );
  smsp_peer smsp_peer_inst (
    .sck(sck_w), .mosi(mosi_w), .miso(peer_miso), .sel(peer_sel),
    .clock_idle_polarity(clock_idle_polarity), .clock_sample_phase(clock_sample_phase), .lsb(lsb), .tx(peer_tx), .rx(peer_rx)
  );

  // ****
  // checking and closing
  // ****
  task automatic chk(input logic ok);
    n_compared++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("ERROR %0t mismatch", $time);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // each read answer against the oldest note
  always @(posedge pclk) if (psel && penable && pready === 1'b1 && !pwrite) begin
    e = exp_q.pop_front();
    m = msk_q.pop_front();
    chk({pslverr, prdata & m} === e);
  end
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      end_sim();
    end
  end

  // ****
  // bus and pin tasks
  // ****
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [7:0] k);
    exp_q.push_back({a > 8'h0c, 24'h0, v & k});
    msk_q.push_back({24'hffffff, k});
    apb(1'b0, a, 8'h00);
  endtask
  task automatic wait_irq(input int n);
    int c;
    c = 0;
    while (xfer_irq !== 1'b1 && c < 5000) begin
      @(negedge pclk);
      c++;
    end
    if (n > 0)
      chk(c == n);
    else
      chk(c < 5000);
  endtask
  // external master, mode 0 msb first, sck at pclk/8
  task automatic ext_bits(input int n);
    repeat (4) @(posedge pclk);
    tb_ss <= 1'b0;
    for (int b = 7; b > 7 - n; b--) begin
      tb_mosi <= s[b];
      repeat (4) @(posedge pclk);
      tb_sck <= 1'b1;
      q[b] = miso_w;
      repeat (4) @(posedge pclk);
      tb_sck <= 1'b0;
    end
    repeat (4) @(posedge pclk);
    tb_ss <= 1'b1;
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 8'h00, 8'hff);
    rd(8'h04, 8'h00, 8'hff);
    rd(8'h10, 8'h00, 8'hff);
    gie <= 1'b1;
    // every mode, rate and bit order as master
    for (int i = 0; i < 8; i++) begin
      r = i[1:0];
      ds = i[2];
      clock_idle_polarity = i[0] ^ i[2];
      clock_sample_phase = i[1];
      lsb = i[0];
      d = $random(seed);
      peer_tx = $random(seed);
      wr_all: begin
        apb(1'b1, 8'h04, {7'h00, ds});
        apb(1'b1, 8'h00, {2'h3, lsb, 1'b1, clock_idle_polarity, clock_sample_phase, r});
        apb(1'b1, 8'h08, d);
      end
      peer_sel = 1'b1;
      // irq rises one edge after the 16th toggle, seen at the negedge after that
      wait_irq(16 * (hn[r] >> ds) + 2);
      peer_sel = 1'b0;
      chk(peer_rx === d);
      rd(8'h04, {1'b1, 6'h00, ds}, 8'hff);
      rd(8'h08, peer_tx, 8'hff);
    end
    // second write while a byte is in flight
    d = $random(seed);
    apb(1'b1, 8'h08, d);
    peer_sel = 1'b1;
    apb(1'b1, 8'h08, ~d);
    rd(8'h04, 8'h40, 8'hc0);
    wait_irq(0);
    peer_sel = 1'b0;
    chk(peer_rx === d);
    rd(8'h08, peer_tx, 8'hff);
    rd(8'h04, 8'h00, 8'hc0);
    // ss as output driven low: plain output, master role kept
    apb(1'b1, 8'h0c, 8'h01);
    repeat (2) @(posedge pclk);
    chk(ss_oe_n === 1'b0 && ss_out === 1'b0);
    rd(8'h0c, 8'h01, 8'hff);
    rd(8'h00, 8'h10, 8'h10);
    apb(1'b1, 8'h0c, 8'h02);
    // select pulled low under master role, irq masked
    gie <= 1'b0;
    tb_ss <= 1'b0;
    repeat (4) @(posedge pclk);
    tb_ss <= 1'b1;
    chk(xfer_irq === 1'b0);
    rd(8'h00, 8'h00, 8'h10);
    rd(8'h04, 8'h80, 8'h80);
    ack <= 1'b1;
    @(posedge pclk);
    ack <= 1'b0;
    rd(8'h04, 8'h00, 8'h80);
    // disabled port ignores a data write
    apb(1'b1, 8'h00, 8'h10);
    rd(8'h00, 8'h10, 8'h10);
    apb(1'b1, 8'h08, 8'h5a);
    repeat (40) @(posedge pclk);
    rd(8'h04, 8'h00, 8'hc0);
    // slave role: partial byte dropped, then a whole byte
    apb(1'b1, 8'h00, 8'h43);
    d = $random(seed);
    s = $random(seed);
    apb(1'b1, 8'h08, d);
    ext_bits(3);
    ext_bits(8);
    chk(q === d);
    rd(8'h08, s, 8'hff);
    end_sim();
  end
endmodule
